// [hw/pec_pkg.sv]
// package: control field layout, event codes and timing counts for the event counters
package pec_pkg;

  // control and status word carrying the counter controls
  localparam int CSR_W = 64;
  localparam int ENABLE_LSB = 44;
  localparam int ENABLE_W = 2;
  localparam int SEL0_LSB = 9;
  localparam int SEL0_W = 4;
  localparam int SEL1_LSB = 13;
  localparam int SEL1_W = 3;
  localparam int RANGE0_BIT = 1;
  localparam int RANGE1_BIT = 2;

  // counter widths: full range and short range, in bits
  localparam int CNT0_W = 16;
  localparam int CNT0_SHORT_W = 12;
  localparam int CNT1_W = 12;
  localparam int CNT1_SHORT_W = 8;

  // power-up value of both counters and of the halving prescalers
  localparam logic CNT_RESET_BIT = 1'b0;

  // cycles from the overflowing event to the interrupt request
  localparam int INTR_DELAY_CYCLES = 6;
  // the pending flag supplies the last of those cycles
  localparam int DELAY_STAGES = INTR_DELAY_CYCLES - 1;

  // counter 0 selections, upper three bits of the select field
  localparam logic [2:0] SEL0_ISSUE_HALF = 3'h0;
  localparam logic [2:0] SEL0_DRY = 3'h1;
  localparam logic [2:0] SEL0_LOAD = 3'h2;
  localparam logic [2:0] SEL0_FROZEN = 3'h3;
  localparam logic [2:0] SEL0_BRANCH = 3'h4;
  localparam logic [2:0] SEL0_CYCLE_GROUP = 3'h5;
  localparam logic [2:0] SEL0_NONISSUE_HALF = 3'h6;
  localparam logic [2:0] SEL0_EXTERNAL = 3'h7;
  // counter 0 full codes inside the cycle group
  localparam logic [3:0] SEL0_PRIV_CYCLES = 4'hb;
  localparam logic [3:0] SEL0_ALL_CYCLES = 4'ha;

  // counter 1 selections
  localparam logic [2:0] SEL1_DCACHE_MISS = 3'h0;
  localparam logic [2:0] SEL1_ICACHE_MISS = 3'h1;
  localparam logic [2:0] SEL1_DUAL_ISSUE = 3'h2;
  localparam logic [2:0] SEL1_MISPREDICT = 3'h3;
  localparam logic [2:0] SEL1_FP_OPERATE = 3'h4;
  localparam logic [2:0] SEL1_INT_OPERATE = 3'h5;
  localparam logic [2:0] SEL1_STORE = 3'h6;
  localparam logic [2:0] SEL1_EXTERNAL = 3'h7;

  // one-cycle event strobes from the pipeline and caches
  typedef struct packed {
    logic issue_single;
    logic issue_dual;
    logic dry_no_issue;
    logic frozen_no_issue;
    logic load_insn;
    logic branch_insn;
    logic privileged_code_mode;
    logic dcache_miss;
    logic icache_miss;
    logic branch_mispredict;
    logic fp_operate;
    logic int_operate;
    logic store_insn;
  } pec_events_t;

  // counter controls pulled out of the control word
  typedef struct packed {
    logic [ENABLE_W-1:0] counter_enable_pair;
    logic [SEL0_W-1:0] counter0_event_select;
    logic [SEL1_W-1:0] counter1_event_select;
    logic counter0_range_select;
    logic counter1_range_select;
  } pec_ctl_t;

endpackage

// [hw/pec_counter.sv]
// free-running event counter with a selectable wrap range
module pec_counter #(
  parameter int WIDTH = 16,
  parameter int SHORT_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic short_range,
  output logic wrap
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic full_top;
  logic short_top;

  // range tops: all ones over the full or the short width
  assign full_top = &count_reg;
  assign short_top = &count_reg[SHORT_W-1:0];

  // overflow pulse in the cycle of the event that crosses the range
  assign wrap = inc & (short_range ? short_top : full_top);

  // counting never stops at a wrap; only reset clears
  assign count_next = inc ? count_reg + {{(WIDTH-1){1'b0}}, 1'b1} : count_reg;

  // count register
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= {WIDTH{pec_pkg::CNT_RESET_BIT}};
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// [hw/pec_delay.sv]
// fixed-length pulse delay line
module pec_delay #(
  parameter int STAGES = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);

  logic [STAGES-1:0] pipe_reg;
  logic [STAGES-1:0] pipe_next;

  // shift one place per clock
  generate
    if (STAGES == 1) begin : g_one
      assign pipe_next = din;
    end else begin : g_many
      assign pipe_next = {pipe_reg[STAGES-2:0], din};
    end
  endgenerate

  assign dout = pipe_reg[STAGES-1];

  // stage registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= pipe_next;
    end
  end

endmodule

// [hw/pec_top.sv]
// two performance event counters with delayed overflow interrupt requests

// What this block does
// - counters start at zero after power-up reset and are never cleared otherwise.
// - counting is gated by the two-bit enable at control bits 45:44.
// - both enable bits zero stops both counters; either bit one runs both.
// - counter 0 interrupts after 2^16 events, or 2^12 with range select set.
// - counter 1 interrupts after 2^12 events, or 2^8 with range select set.
// - interrupt request rises six cycles after the overflowing event.
// - counters keep counting after overflow regardless of interrupt state.
// - an interrupt is lost only if the counter wraps again before service.
// - no path exists to read intermediate counter values.
// - aborted and reissued loads each count once per attempt.
// - on icache miss counting, no instruction completes before interrupt entry.
// - on mispredict counting, at most two instructions complete before service.
// - counter 0 codes 000X and 110X count issues and non-issues halved.
// - counter 0 codes 001X and 011X count dry and frozen no-issue cycles.
// - counter 0 codes 010X count loads and 100X count branch-class instructions.
// - counter 0 code 1011 counts privileged cycles, 1010 counts all cycles.
// - counter 0 111X and counter 1 111 count external input bits 0, 1.
// - counter 1 codes 000 and 001 count data and instruction cache misses.
// - counter 1 codes 010 dual issues, 011 all mispredictions.
// - counter 1 codes 100 fp operates, 101 integer operates, 110 stores.
module pec_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [pec_pkg::CSR_W-1:0] ICACHE_CTL_STATUS_REG,
  input pec_pkg::pec_events_t EVENTS,
  input wire logic [1:0] EXTERNAL_COUNT_INPUT,
  input wire logic [1:0] INTR_CLEAR_N,
  output logic COUNTER0_INTR_REQ,
  output logic COUNTER1_INTR_REQ
);

  // control fields
  // enable pair, select codes and range bits
  pec_pkg::pec_ctl_t ctl;
  logic count_enabled;
  logic [2:0] sel0_group;
  logic [3:0] sel0_code;
  logic [2:0] sel1_code;

  // field extraction from the control word
  assign ctl.counter_enable_pair =
    ICACHE_CTL_STATUS_REG[pec_pkg::ENABLE_LSB +: pec_pkg::ENABLE_W];
  assign ctl.counter0_event_select =
    ICACHE_CTL_STATUS_REG[pec_pkg::SEL0_LSB +: pec_pkg::SEL0_W];
  assign ctl.counter1_event_select =
    ICACHE_CTL_STATUS_REG[pec_pkg::SEL1_LSB +: pec_pkg::SEL1_W];
  assign ctl.counter0_range_select = ICACHE_CTL_STATUS_REG[pec_pkg::RANGE0_BIT];
  assign ctl.counter1_range_select = ICACHE_CTL_STATUS_REG[pec_pkg::RANGE1_BIT];

  // either enable bit runs both counters, both clear stop them
  assign count_enabled = |ctl.counter_enable_pair;

  // select codes split for decode
  assign sel0_code = ctl.counter0_event_select;
  assign sel0_group = sel0_code[3:1];
  assign sel1_code = ctl.counter1_event_select;

  // counter 0 select decode
  // one class wire per select group or full code
  logic pick0_issue_half;
  logic pick0_dry;
  logic pick0_load;
  logic pick0_frozen;
  logic pick0_branch;
  logic pick0_priv;
  logic pick0_cycles;
  logic pick0_nonissue_half;
  logic pick0_external;

  // one wire per counter 0 input class
  assign pick0_issue_half = (sel0_group == pec_pkg::SEL0_ISSUE_HALF);
  assign pick0_dry = (sel0_group == pec_pkg::SEL0_DRY);
  assign pick0_load = (sel0_group == pec_pkg::SEL0_LOAD);
  assign pick0_frozen = (sel0_group == pec_pkg::SEL0_FROZEN);
  assign pick0_branch = (sel0_group == pec_pkg::SEL0_BRANCH);
  assign pick0_priv = (sel0_code == pec_pkg::SEL0_PRIV_CYCLES);
  assign pick0_cycles = (sel0_code == pec_pkg::SEL0_ALL_CYCLES);
  assign pick0_nonissue_half = (sel0_group == pec_pkg::SEL0_NONISSUE_HALF);
  assign pick0_external = (sel0_group == pec_pkg::SEL0_EXTERNAL);

  // halving prescalers for the issue and non-issue selections
  // each keeps its phase while deselected or disabled
  logic issue_half_reg;
  logic issue_half_next;
  logic nonissue_half_reg;
  logic nonissue_half_next;
  logic issue_any;
  logic nonissue_cycle;
  logic issue_run;
  logic nonissue_run;
  logic [1:0] issue_units;
  logic [1:0] issue_sum;
  logic issue_half_inc;
  logic nonissue_half_inc;

  // issues this cycle: none, one, or two for a dual issue
  assign issue_any = EVENTS.issue_single | EVENTS.issue_dual;
  assign nonissue_cycle = ~issue_any;
  assign issue_units = EVENTS.issue_dual ? 2'h2 : {1'b0, EVENTS.issue_single};

  // prescalers only move while their selection is live and counting runs
  assign issue_run = count_enabled & pick0_issue_half;
  assign nonissue_run = count_enabled & pick0_nonissue_half;

  // issue halving: a dual issue adds exactly one, singles pair up
  assign issue_sum = {1'b0, issue_half_reg} + issue_units;
  assign issue_half_inc = issue_run & issue_sum[1];
  assign issue_half_next = issue_run ? issue_sum[0] : issue_half_reg;

  // non-issue halving: every second idle cycle counts
  assign nonissue_half_inc = nonissue_run & nonissue_cycle & nonissue_half_reg;
  assign nonissue_half_next = (nonissue_run & nonissue_cycle) ?
    ~nonissue_half_reg : nonissue_half_reg;

  // prescaler registers, cleared only by reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      issue_half_reg <= pec_pkg::CNT_RESET_BIT;
      nonissue_half_reg <= pec_pkg::CNT_RESET_BIT;
    end else begin
      issue_half_reg <= issue_half_next;
      nonissue_half_reg <= nonissue_half_next;
    end
  end

  // counter 0 increment selection
  // at most one count per cycle reaches the counter
  logic ev0_dry;
  logic ev0_load;
  logic ev0_frozen;
  logic ev0_branch;
  logic ev0_priv;
  logic ev0_cycle;
  logic ev0_external;
  logic ev0_plain;
  logic inc0;

  // gated per-class increments, at most one per cycle
  assign ev0_dry = pick0_dry & EVENTS.dry_no_issue & nonissue_cycle;
  assign ev0_frozen = pick0_frozen & EVENTS.frozen_no_issue & nonissue_cycle;
  // each load attempt strobes once, aborted or not
  assign ev0_load = pick0_load & EVENTS.load_insn;
  assign ev0_branch = pick0_branch & EVENTS.branch_insn;
  assign ev0_priv = pick0_priv & EVENTS.privileged_code_mode;
  assign ev0_cycle = pick0_cycles;
  assign ev0_external = pick0_external & EXTERNAL_COUNT_INPUT[0];

  // the selections are exclusive, so an or is a mux
  assign ev0_plain = ev0_dry | ev0_load | ev0_frozen | ev0_branch |
    ev0_priv | ev0_cycle | ev0_external;
  assign inc0 = count_enabled & ev0_plain | issue_half_inc | nonissue_half_inc;

  // counter 1 select decode
  // one wire per three-bit select code
  logic pick1_dcache;
  logic pick1_icache;
  logic pick1_dual;
  logic pick1_mispredict;
  logic pick1_fp;
  logic pick1_int;
  logic pick1_store;
  logic pick1_external;

  // select code compares for counter 1
  assign pick1_dcache = (sel1_code == pec_pkg::SEL1_DCACHE_MISS);
  assign pick1_icache = (sel1_code == pec_pkg::SEL1_ICACHE_MISS);
  assign pick1_dual = (sel1_code == pec_pkg::SEL1_DUAL_ISSUE);
  assign pick1_mispredict = (sel1_code == pec_pkg::SEL1_MISPREDICT);
  assign pick1_fp = (sel1_code == pec_pkg::SEL1_FP_OPERATE);
  assign pick1_int = (sel1_code == pec_pkg::SEL1_INT_OPERATE);
  assign pick1_store = (sel1_code == pec_pkg::SEL1_STORE);
  assign pick1_external = (sel1_code == pec_pkg::SEL1_EXTERNAL);

  // counter 1 increment selection
  // gated events, one class live at a time
  logic ev1_dcache;
  logic ev1_icache;
  logic ev1_dual;
  logic ev1_mispredict;
  logic ev1_fp;
  logic ev1_int;
  logic ev1_store;
  logic ev1_external;
  logic inc1;

  // cache miss classes
  assign ev1_dcache = pick1_dcache & EVENTS.dcache_miss;
  assign ev1_icache = pick1_icache & EVENTS.icache_miss;
  // issue and prediction classes
  assign ev1_dual = pick1_dual & EVENTS.issue_dual;
  assign ev1_mispredict = pick1_mispredict & EVENTS.branch_mispredict;
  // instruction mix classes
  assign ev1_fp = pick1_fp & EVENTS.fp_operate;
  assign ev1_int = pick1_int & EVENTS.int_operate;
  assign ev1_store = pick1_store & EVENTS.store_insn;
  // external pin, bit 1
  assign ev1_external = pick1_external & EXTERNAL_COUNT_INPUT[1];

  // exclusive codes, gated by the shared enable
  assign inc1 = count_enabled & (ev1_dcache | ev1_icache | ev1_dual |
    ev1_mispredict | ev1_fp | ev1_int | ev1_store | ev1_external);

  // the two counters; their values stay internal
  // a wrap is a pulse on the overflowing event
  logic wrap0;
  logic wrap1;

  // counter 0: full or short range
  pec_counter #(
    .WIDTH(pec_pkg::CNT0_W),
    .SHORT_W(pec_pkg::CNT0_SHORT_W)
  ) u_counter0 (
    .clk(CLOCK),
    .rst(RST),
    .inc(inc0),
    .short_range(ctl.counter0_range_select),
    .wrap(wrap0)
  );

  // counter 1: full or short range
  pec_counter #(
    .WIDTH(pec_pkg::CNT1_W),
    .SHORT_W(pec_pkg::CNT1_SHORT_W)
  ) u_counter1 (
    .clk(CLOCK),
    .rst(RST),
    .inc(inc1),
    .short_range(ctl.counter1_range_select),
    .wrap(wrap1)
  );

  // no port carries a count out; only the requests leave

  // overflow to interrupt request timing
  // wrap pulse delayed, then latched as a request
  logic wrap0_late;
  logic wrap1_late;

  // fixed latency keeps the completion window short for miss and mispredict
  pec_delay #(
    .STAGES(pec_pkg::DELAY_STAGES)
  ) u_delay0 (
    .clk(CLOCK),
    .rst(RST),
    .din(wrap0),
    .dout(wrap0_late)
  );

  // same fixed latency for counter 1, icache miss path included
  pec_delay #(
    .STAGES(pec_pkg::DELAY_STAGES)
  ) u_delay1 (
    .clk(CLOCK),
    .rst(RST),
    .din(wrap1),
    .dout(wrap1_late)
  );

  // pending interrupt requests
  // set by a late wrap, cleared by an active-low strobe
  logic pend0_reg;
  logic pend0_next;
  logic pend1_reg;
  logic pend1_next;
  logic clear0;
  logic clear1;

  // write-zero clear strobes from software
  assign clear0 = ~INTR_CLEAR_N[0];
  assign clear1 = ~INTR_CLEAR_N[1];

  // a new overflow beats a clear in the same cycle; a second one merges
  assign pend0_next = wrap0_late | (pend0_reg & ~clear0);
  assign pend1_next = wrap1_late | (pend1_reg & ~clear1);

  // request flags
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pend0_reg <= 1'b0;
      pend1_reg <= 1'b0;
    end else begin
      pend0_reg <= pend0_next;
      pend1_reg <= pend1_next;
    end
  end

  // requests come straight from the flags
  assign COUNTER0_INTR_REQ = pend0_reg;
  assign COUNTER1_INTR_REQ = pend1_reg;

endmodule

// [verif/pec_top_sva.sv]
// checker: timing relations of the overflow requests
module pec_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [pec_pkg::CSR_W-1:0] ICACHE_CTL_STATUS_REG,
  input pec_pkg::pec_events_t EVENTS,
  input wire logic [1:0] EXTERNAL_COUNT_INPUT,
  input wire logic [1:0] INTR_CLEAR_N,
  input wire logic COUNTER0_INTR_REQ,
  input wire logic COUNTER1_INTR_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sel0;
  logic [2:0] sel1;
  logic en, iss, c0_cand, c1_cand;
  logic [7:0] c0_vec, c1_vec;
  logic [12:0] since_rst;
  // raw event each counter could take this cycle
  assign sel0 = ICACHE_CTL_STATUS_REG[pec_pkg::SEL0_LSB +: pec_pkg::SEL0_W];
  assign sel1 = ICACHE_CTL_STATUS_REG[pec_pkg::SEL1_LSB +: pec_pkg::SEL1_W];
  assign en = |ICACHE_CTL_STATUS_REG[pec_pkg::ENABLE_LSB +: pec_pkg::ENABLE_W];
  assign iss = EVENTS.issue_single | EVENTS.issue_dual;
  assign c0_vec = {EXTERNAL_COUNT_INPUT[0], ~iss, EVENTS.privileged_code_mode | ~sel0[0],
    EVENTS.branch_insn, EVENTS.frozen_no_issue, EVENTS.load_insn, EVENTS.dry_no_issue, iss};
  assign c1_vec = {EXTERNAL_COUNT_INPUT[1], EVENTS.store_insn, EVENTS.int_operate,
    EVENTS.fp_operate, EVENTS.branch_mispredict, EVENTS.issue_dual, EVENTS.icache_miss,
    EVENTS.dcache_miss};
  assign c0_cand = en & c0_vec[sel0[3:1]];
  assign c1_cand = en & c1_vec[sel1];
  // cycles since reset, saturating at 4096
  always_ff @(posedge CLOCK) begin
    if (RST) since_rst <= 13'h0;
    else if (!since_rst[12]) since_rst <= since_rst + 13'h1;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_reset_quiet;
    $fell(RST) |-> !COUNTER0_INTR_REQ && !COUNTER1_INTR_REQ;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("request high after reset");
  property p_rise0;
    $rose(COUNTER0_INTR_REQ) |-> $past(c0_cand, 6);
  endproperty
  a_rise0: assert property (p_rise0) else $error("counter 0 request without event");
  property p_rise1;
    $rose(COUNTER1_INTR_REQ) |-> $past(c1_cand, 6);
  endproperty
  a_rise1: assert property (p_rise1) else $error("counter 1 request without event");
  property p_hold0;
    COUNTER0_INTR_REQ && INTR_CLEAR_N[0] |=> COUNTER0_INTR_REQ;
  endproperty
  a_hold0: assert property (p_hold0) else $error("counter 0 request dropped");
  property p_hold1;
    COUNTER1_INTR_REQ && INTR_CLEAR_N[1] |=> COUNTER1_INTR_REQ;
  endproperty
  a_hold1: assert property (p_hold1) else $error("counter 1 request dropped");
  property p_clr0;
    !INTR_CLEAR_N[0] && !$past(c0_cand, 5) |=> !COUNTER0_INTR_REQ;
  endproperty
  a_clr0: assert property (p_clr0) else $error("counter 0 clear ignored");
  property p_clr1;
    !INTR_CLEAR_N[1] && !$past(c1_cand, 5) |=> !COUNTER1_INTR_REQ;
  endproperty
  a_clr1: assert property (p_clr1) else $error("counter 1 clear ignored");
  property p_min0;
    $rose(COUNTER0_INTR_REQ) |-> since_rst[12];
  endproperty
  a_min0: assert property (p_min0) else $error("counter 0 overflow too early");
  property p_min1;
    $rose(COUNTER1_INTR_REQ) |-> since_rst > 13'h100;
  endproperty
  a_min1: assert property (p_min1) else $error("counter 1 overflow too early");
  c_ovf0: cover property ($rose(COUNTER0_INTR_REQ));
  c_ovf1: cover property ($rose(COUNTER1_INTR_REQ));
  c_clr1: cover property (COUNTER1_INTR_REQ ##1 !COUNTER1_INTR_REQ);
endmodule

bind pec_top pec_checker u_chk (.CLOCK, .RST, .ICACHE_CTL_STATUS_REG, .EVENTS,
  .EXTERNAL_COUNT_INPUT, .INTR_CLEAR_N, .COUNTER0_INTR_REQ, .COUNTER1_INTR_REQ);

// [verif/pec_event_source.sv]
// pipeline and pin event source for the counter block
module pec_event_source (
  input wire logic clk,
  input wire logic [3:0] dens,
  output pec_pkg::pec_events_t events,
  output logic [1:0] ext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [14:0] hit;
  initial begin
    events = 13'h0;
    ext = 2'h0;
  end
  // fresh strobes each falling edge, density out of 16, never single and dual together
  always @(negedge clk) begin
    for (int i = 0; i < 15; i++) hit[i] = ($urandom % 16) < dens;
    events <= {hit[12] & ~hit[11], hit[11:0]};
    ext <= hit[14:13];
  end
endmodule

// [verif/test_perf_event_counters.sv]
// self-checking bench for the event counter block
module test_perf_event_counters;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, r0, r1, iss;
  logic [63:0] ctl;
  pec_pkg::pec_events_t events;
  logic [1:0] ext, clr_n;
  logic req0, req1;
  logic [3:0] dens, s0;
  logic [2:0] s1;
  logic [7:0] v0, v1;
  int failures, total_checks, c0, c1, ph, d0, d1, i0, i1, m0, m1;

  pec_top u_dut (.CLOCK(clock), .RST(rst), .ICACHE_CTL_STATUS_REG(ctl), .EVENTS(events),
    .EXTERNAL_COUNT_INPUT(ext), .INTR_CLEAR_N(clr_n), .COUNTER0_INTR_REQ(req0),
    .COUNTER1_INTR_REQ(req1));
  pec_event_source u_src (.clk(clock), .dens(dens), .events(events), .ext(ext));

  initial clock = 1'b0;
  always #2.5 clock = ~clock;
  assign s0 = ctl[pec_pkg::SEL0_LSB +: pec_pkg::SEL0_W];
  assign s1 = ctl[pec_pkg::SEL1_LSB +: pec_pkg::SEL1_W];

  // reference counters, halving prescaler and six-edge request delay
  always @(posedge clock) begin
    if (rst) begin
      c0 = 0; c1 = 0; ph = 0; d0 = 0; d1 = 0; r0 = 1'b0; r1 = 1'b0;
    end else begin
      i0 = 0;
      i1 = 0;
      iss = events.issue_single | events.issue_dual;
      v0 = {ext[0], ~iss, events.privileged_code_mode | ~s0[0], events.branch_insn,
        events.frozen_no_issue & ~iss, events.load_insn, events.dry_no_issue & ~iss, iss};
      v1 = {ext[1], events.store_insn, events.int_operate, events.fp_operate,
        events.branch_mispredict, events.issue_dual, events.icache_miss, events.dcache_miss};
      if (ctl[45:44] != 2'h0) begin
        i0 = v0[s0[3:1]];
        i1 = v1[s1];
        if ((s0[3:1] == 3'h0 || s0[3:1] == 3'h6) && !events.issue_dual && i0) begin
          i0 = ph;
          ph = 1 - ph;
        end
      end
      r0 = d0[4] | (r0 & clr_n[0]);
      r1 = d1[4] | (r1 & clr_n[1]);
      m0 = ctl[pec_pkg::RANGE0_BIT] ? 16'h0fff : 16'hffff;
      m1 = ctl[pec_pkg::RANGE1_BIT] ? 12'h0ff : 12'hfff;
      d0 = (d0 << 1) | (i0 & ((c0 & m0) == m0));
      d1 = (d1 << 1) | (i1 & ((c1 & m1) == m1));
      c0 = (c0 + i0) & 16'hffff;
      c1 = (c1 + i1) & 12'hfff;
    end
  end

  task automatic chk(input logic got, input logic exp, input int n);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t request %0d is %b", $time, n, got);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // both requests against the reference every cycle
  always @(negedge clock) begin
    chk(req0, r0, 0);
    chk(req1, r1, 1);
  end

  // rare independent clear strobes
  always @(negedge clock) clr_n <= {$urandom % 24 != 0, $urandom % 24 != 0};

  initial begin
    #(98000 * 5);
    failures++;
    end_of_test();
  end

  // every select code except counter 0 codes 1100 and 1101 with short ranges, then halved non-issues, then full 2^16 range
  initial begin
    void'($urandom(42));
    rst = 1'b1;
    ctl = 64'h0;
    dens = 4'h8;
    clr_n = 2'h3;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    for (int k = 0; k < 16; k++) begin
      if (k == 12 || k == 13) continue;
      ctl = {$urandom, $urandom};
      ctl[pec_pkg::SEL0_LSB +: pec_pkg::SEL0_W] = k[3:0];
      ctl[pec_pkg::SEL1_LSB +: pec_pkg::SEL1_W] = k[2:0];
      ctl[pec_pkg::RANGE0_BIT] = 1'b1;
      ctl[pec_pkg::RANGE1_BIT] = 1'b1;
      ctl[45:44] = 2'h0;
      dens = 4'($urandom % 13 + 2);
      repeat (200) @(negedge clock);
      ctl[45:44] = 2'(k % 3 + 1);
      repeat (800) @(negedge clock);
    end
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    ctl[pec_pkg::SEL0_LSB +: pec_pkg::SEL0_W] = 4'hc;
    ctl[45:44] = 2'h1;
    dens = 4'h1;
    repeat (10000) @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    ctl = 64'h0;
    ctl[pec_pkg::SEL0_LSB +: pec_pkg::SEL0_W] = 4'ha;
    ctl[pec_pkg::SEL1_LSB +: pec_pkg::SEL1_W] = 3'h7;
    ctl[45:44] = 2'h2;
    repeat (65560) @(negedge clock);
    end_of_test();
  end
endmodule
